/* fpp_host.sv */
// Purpose: controller that drives a flash in programmer mode over its parallel pins
// Assumes: software register port, read data one cycle after the read strobe
// Notes:   data bytes stream in through the data register, one at a time
//
// Functional notes
// - Hold mode pins at 0,1,1 and supply the flash input clock.
// - Strobe decode: read, output disable, command write, chip disable.
// - Write-permit pin high while issuing program or erase commands.
// - Memory-read: one write of 00 or 05, then any byte reads.
// - Program: write 40 or 45, then 128 data writes, 129 total.
// - Erase: two writes of the same code, 20 or 25.
// - Status read: two writes of 71, then reads return error code.
// - Program always sends 128 bytes, unused ones padded with FF.
// - Program address has low seven bits zero, else programming error.
// - Address taken only in second program cycle, none presented later; code presents the block address on every data write.
// - No command writes while programming or erasing runs.
// - Each 128-byte block programmed once until its array is erased; code refuses a repeat of the last programmed block only.
// - Completion polled on data bit 7; bit 6 gives pass or fail.
`timescale 1ns/1ns
module fpp_host
	import fpp_pkg::*;
#(
	parameter int unsigned HALF_DIV = CLK_HALF_DIV
) (
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	input  wire logic              clk_en,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	output logic                   fl_clk,
	output logic                   mode_select_2,
	output logic                   mode_select_1,
	output logic                   mode_select_0,
	output logic                   flash_write_permit,
	output logic                   fl_ce_n,
	output logic                   fl_oe_n,
	output logic                   fl_we_n,
	output logic [ADDR_W-1:0]      fl_addr,
	output logic [DATA_W-1:0]      fl_data_o,
	output logic                   fl_data_oe,
	input  wire logic [DATA_W-1:0] fl_data_i
);

	// Command byte for an operation and array
	function automatic logic [7:0] cmd_code(input fpp_op_t op, input logic boot);
		case (op)
			OP_MREAD: cmd_code = boot ? CMD_READ_BOOT : CMD_READ_USER;
			OP_PROG:  cmd_code = boot ? CMD_PROG_BOOT : CMD_PROG_USER;
			OP_ERASE: cmd_code = boot ? CMD_ERASE_BOOT : CMD_ERASE_USER;
			default:  cmd_code = CMD_STATUS;
		endcase
	endfunction

	fpp_state_t        state_r;
	fpp_op_t           op_r;
	logic              boot_r;
	logic [ADDR_W-1:0] addr_r;
	logic [DATA_W-1:0] din_s1_r;
	logic [DATA_W-1:0] din_s2_r;
	logic [DATA_W-1:0] dbuf_r;
	logic              dvld_r;
	logic              pad_r;
	logic [7:0]        cnt_r;
	logic              issued_r;
	logic              mread_r;
	logic              done_r;
	logic              normal_r;
	logic              abnormal_r;
	logic              refused_r;
	logic [DATA_W-1:0] rd_byte_r;
	logic [DATA_W-1:0] rcode_r;
	logic              fwp_r;
	logic [ADDR_W-1:0] blk_addr_r;
	logic              blk_boot_r;
	logic              blk_vld_r;

	logic              go;
	logic              wr_data;
	logic              take_data;
	logic              cyc_start;
	logic              cyc_busy;
	logic              cyc_done;
	logic [DATA_W-1:0] cyc_rdata;
	fpp_req_t          req;
	fpp_pins_t         pins;
	logic [ADDR_W-1:0] prog_addr;
	logic              reprog;
	fpp_op_t           op_in;

	// Fixed programmer-mode straps
	assign mode_select_2 = MODE_SEL_2;
	assign mode_select_1 = MODE_SEL_1;
	assign mode_select_0 = MODE_SEL_0;

	// Flash input clock
	fpp_clkdiv #(
		.HALF_DIV (HALF_DIV)
	) u_clkdiv (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.clk_en  (clk_en),
		.clk_out (fl_clk)
	);

	// Pin data come from another domain; two flops before use
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			din_s1_r <= 8'h00;
			din_s2_r <= 8'h00;
		end else if (clk_en) begin
			din_s1_r <= fl_data_i;
			din_s2_r <= din_s1_r;
		end
	end

	// Software strobes
	assign op_in   = fpp_op_t'(reg_wdata[CTRL_OP_LSB +: 3]);
	assign go      = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_GO_BIT];
	assign wr_data = reg_wr && (reg_addr == REG_DATA);

	// Block address is forced to a page boundary
	assign prog_addr = {addr_r[ADDR_W-1:PAGE_LSB], 7'h00};
	assign reprog    = blk_vld_r && (blk_addr_r == prog_addr) &&
		(blk_boot_r == reg_wdata[CTRL_BOOT_BIT]);

	// Address register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_r <= ADDR_RST;
		end else if (clk_en && reg_wr && (reg_addr == REG_ADDR)) begin
			addr_r <= reg_wdata[ADDR_W-1:0];
		end
	end

	// Issue one bus cycle per step; issued_r stops a second start
	assign cyc_start = clk_en && !cyc_busy && !issued_r && !cyc_done &&
		((state_r == ST_CMD1) || (state_r == ST_CMD2) || (state_r == ST_POLL) ||
		(state_r == ST_RDBYTE) || ((state_r == ST_PDATA) && (dvld_r || pad_r)));
	assign take_data = cyc_start && (state_r == ST_PDATA) && dvld_r;

	// Bus cycle request for the current step
	always_comb begin
		req = '{1'b0, addr_r, 8'h00};
		case (state_r)
			ST_CMD1, ST_CMD2: begin
				req.wr   = 1'b1;
				req.data = cmd_code(op_r, boot_r);
			end
			ST_PDATA: begin
				req.wr   = 1'b1;
				req.addr = prog_addr; // Same address held after second cycle
				// The byte that asked for padding still goes out first
				req.data = dvld_r ? dbuf_r : FILL_BYTE;
			end
			default: begin
				req.wr = 1'b0;
			end
		endcase
	end

	fpp_cycle u_cycle (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.clk_en   (clk_en),
		.start    (cyc_start),
		.req      (req),
		.din_sync (din_s2_r),
		.busy     (cyc_busy),
		.done     (cyc_done),
		.rdata    (cyc_rdata),
		.pins     (pins)
	);

	assign fl_ce_n    = pins.ce_n;
	assign fl_oe_n    = pins.oe_n;
	assign fl_we_n    = pins.we_n;
	assign fl_addr    = pins.addr;
	assign fl_data_o  = pins.dout;
	assign fl_data_oe = pins.doe;

	// Streamed program byte; a write while one is still pending is dropped
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dbuf_r <= 8'h00;
			dvld_r <= 1'b0;
			pad_r  <= 1'b0;
		end else if (clk_en) begin
			if (wr_data && (state_r == ST_PDATA) && !dvld_r) begin
				dbuf_r <= reg_wdata[DATA_W-1:0];
				dvld_r <= 1'b1;
				pad_r  <= pad_r | reg_wdata[DATA_PAD_BIT]; // Fill the rest
			end else if (take_data) begin
				dvld_r <= 1'b0;
			end
			if (state_r == ST_IDLE) begin
				pad_r  <= 1'b0;
				dvld_r <= 1'b0;
			end
		end
	end

	// Main sequencer; no command issued while a program or erase polls
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r  <= ST_IDLE;
			op_r     <= OP_MREAD;
			boot_r   <= 1'b0;
			cnt_r    <= 8'h00;
			issued_r <= 1'b0;
		end else if (clk_en) begin
			if (cyc_start) begin
				issued_r <= 1'b1;
			end else if (cyc_done) begin
				issued_r <= 1'b0;
			end
			case (state_r)
				ST_IDLE: begin
					if (go) begin
						op_r   <= op_in;
						boot_r <= reg_wdata[CTRL_BOOT_BIT];
						cnt_r  <= 8'h00;
						case (op_in)
							OP_RBYTE: state_r <= mread_r ? ST_RDBYTE : ST_IDLE;
							OP_PROG:  state_r <= reprog ? ST_IDLE : ST_CMD1;
							OP_MREAD, OP_ERASE, OP_STAT: state_r <= ST_CMD1;
							default:  state_r <= ST_IDLE;
						endcase
					end
				end
				ST_CMD1: begin
					if (cyc_done) begin
						case (op_r)
							OP_MREAD: state_r <= ST_IDLE;
							OP_PROG:  state_r <= ST_PDATA;
							default:  state_r <= ST_CMD2; // Code repeated
						endcase
					end
				end
				ST_CMD2: begin
					if (cyc_done) begin
						state_r <= (op_r == OP_STAT) ? ST_RDBYTE : ST_POLL;
					end
				end
				ST_PDATA: begin
					if (cyc_done) begin
						cnt_r <= cnt_r + 8'h01;
						if (cnt_r == 8'(PROG_BYTES - 1)) begin // 128 data writes
							state_r <= ST_POLL;
						end
					end
				end
				ST_POLL: begin
					// Bit 7 set means ended, either way
					if (cyc_done && cyc_rdata[POLL_END_BIT]) begin
						state_r <= ST_IDLE;
					end
				end
				ST_RDBYTE: begin
					if (cyc_done) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Device mode tracking: read mode from power-up, lost after other commands
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mread_r <= 1'b1;
		end else if (clk_en && (state_r == ST_CMD1) && cyc_done) begin
			mread_r <= (op_r == OP_MREAD);
		end
	end

	// Write permit high for the whole program or erase operation
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fwp_r <= 1'b0;
		end else if (clk_en) begin
			fwp_r <= (state_r != ST_IDLE) && ((op_r == OP_PROG) || (op_r == OP_ERASE));
		end
	end
	assign flash_write_permit = fwp_r;

	// Remember the last programmed block; erase of its array releases it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			blk_addr_r <= ADDR_RST;
			blk_boot_r <= 1'b0;
			blk_vld_r  <= 1'b0;
		end else if (clk_en && (state_r == ST_CMD1) && cyc_done) begin
			if (op_r == OP_PROG) begin
				blk_addr_r <= prog_addr;
				blk_boot_r <= boot_r;
				blk_vld_r  <= 1'b1;
			end else if ((op_r == OP_ERASE) && (boot_r == blk_boot_r)) begin
				blk_vld_r <= 1'b0;
			end
		end
	end

	// Results; done is sticky and a finish in the go cycle still sets it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			done_r     <= 1'b0;
			normal_r   <= 1'b0;
			abnormal_r <= 1'b0;
			refused_r  <= 1'b0;
			rd_byte_r  <= 8'h00;
			rcode_r    <= 8'h00;
		end else if (clk_en) begin
			if (go) begin
				done_r    <= 1'b0;
				refused_r <= (state_r != ST_IDLE) ||
					((op_in == OP_RBYTE) && !mread_r) || ((op_in == OP_PROG) && reprog);
				if (state_r == ST_IDLE) begin
					normal_r   <= 1'b0;
					abnormal_r <= 1'b0;
				end
			end
			if (cyc_done && (state_r == ST_POLL) && cyc_rdata[POLL_END_BIT]) begin
				normal_r   <= cyc_rdata[POLL_OK_BIT];
				abnormal_r <= ~cyc_rdata[POLL_OK_BIT];
				done_r     <= 1'b1;
			end
			if (cyc_done && (state_r == ST_RDBYTE)) begin
				if (op_r == OP_STAT) begin
					rcode_r    <= cyc_rdata;
					abnormal_r <= cyc_rdata[RC_ABNORMAL];
				end else begin
					rd_byte_r <= cyc_rdata;
				end
				done_r <= 1'b1;
			end
			if (cyc_done && (state_r == ST_CMD1) && (op_r == OP_MREAD)) begin
				done_r <= 1'b1;
			end
			if (go && (state_r == ST_IDLE) && (((op_in == OP_RBYTE) && !mread_r) ||
				((op_in == OP_PROG) && reprog))) begin
				done_r <= 1'b1;
			end
		end
	end

	// Register read port, data one cycle after the strobe
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (clk_en) begin
			reg_rdata <= 32'h0000_0000;
			if (reg_rd) begin
				case (reg_addr)
					REG_CTRL: reg_rdata <= CTRL_RST | {27'h0, boot_r, op_r, 1'b0};
					REG_ADDR: reg_rdata <= {12'h000, addr_r};
					REG_DATA: reg_rdata <= {24'h000000, rd_byte_r};
					REG_STAT: reg_rdata <= {8'h00, rcode_r, rd_byte_r, 1'b0, mread_r,
						refused_r, abnormal_r, normal_r, done_r,
						(state_r == ST_PDATA) && !dvld_r && !pad_r, state_r != ST_IDLE};
					default:  reg_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // fpp_host

/* fpp_pkg.sv */
// Purpose: shared constants, types and helpers of the flash parallel programmer port
// Assumes: 50 MHz system clock, 8-bit flash data, 20-bit flash address
// Notes:   strobe timing figures are plain defaults, tune them for the socket in use
package fpp_pkg;

	// Clocking
	localparam int unsigned SYS_CLK_HZ    = 50_000_000;
	localparam int unsigned SYS_CLK_NS    = 20;
	localparam int unsigned FLASH_CLK_HZ  = 6_000_000;
	localparam int unsigned CLK_HALF_DIV  = SYS_CLK_HZ / (2 * FLASH_CLK_HZ);

	// Strobe timing, least times
	localparam int unsigned T_SETUP_NS    = 100;
	localparam int unsigned T_PULSE_NS    = 200;
	localparam int unsigned T_HOLD_NS     = 100;

	// Least time to whole cycles, never below one
	function automatic int unsigned fpp_ns2cyc(input int unsigned ns);
		int unsigned c;
		c = (ns + SYS_CLK_NS - 1) / SYS_CLK_NS;
		return (c == 0) ? 1 : c;
	endfunction

	localparam int unsigned SETUP_CYC     = fpp_ns2cyc(T_SETUP_NS);
	localparam int unsigned PULSE_CYC     = fpp_ns2cyc(T_PULSE_NS);
	localparam int unsigned HOLD_CYC      = fpp_ns2cyc(T_HOLD_NS);

	// Flash port geometry
	localparam int unsigned ADDR_W        = 20;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned PROG_BYTES    = 128;
	localparam int unsigned PAGE_LSB      = 7;

	// Mode pin levels for programmer mode
	localparam logic        MODE_SEL_2    = 1'h0;
	localparam logic        MODE_SEL_1    = 1'h1;
	localparam logic        MODE_SEL_0    = 1'h1;

	// Command bytes
	localparam logic [7:0]  CMD_READ_USER  = 8'h00;
	localparam logic [7:0]  CMD_READ_BOOT  = 8'h05;
	localparam logic [7:0]  CMD_PROG_USER  = 8'h40;
	localparam logic [7:0]  CMD_PROG_BOOT  = 8'h45;
	localparam logic [7:0]  CMD_ERASE_USER = 8'h20;
	localparam logic [7:0]  CMD_ERASE_BOOT = 8'h25;
	localparam logic [7:0]  CMD_STATUS     = 8'h71;
	localparam logic [7:0]  FILL_BYTE      = 8'hFF;

	// Polling and return code bits
	localparam int unsigned POLL_END_BIT   = 7;
	localparam int unsigned POLL_OK_BIT    = 6;
	localparam int unsigned RC_ABNORMAL    = 7;

	// Software register map
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_ADDR      = 8'h04;
	localparam logic [7:0]  REG_DATA      = 8'h08;
	localparam logic [7:0]  REG_STAT      = 8'h0C;
	localparam int unsigned CTRL_GO_BIT   = 0;
	localparam int unsigned CTRL_OP_LSB   = 1;
	localparam int unsigned CTRL_BOOT_BIT = 4;
	localparam int unsigned DATA_PAD_BIT  = 8;
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;

	typedef enum logic [2:0] {
		OP_MREAD = 3'h0,
		OP_RBYTE = 3'h1,
		OP_PROG  = 3'h2,
		OP_ERASE = 3'h3,
		OP_STAT  = 3'h4
	} fpp_op_t;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_CMD1   = 6'b000010,
		ST_CMD2   = 6'b000100,
		ST_PDATA  = 6'b001000,
		ST_POLL   = 6'b010000,
		ST_RDBYTE = 6'b100000
	} fpp_state_t;

	typedef enum logic [3:0] {
		PH_IDLE  = 4'b0001,
		PH_SETUP = 4'b0010,
		PH_PULSE = 4'b0100,
		PH_HOLD  = 4'b1000
	} fpp_phase_t;

	typedef struct packed {
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fpp_req_t;

	typedef struct packed {
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic              doe;
	} fpp_pins_t;

	localparam fpp_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, ADDR_RST, 8'h00, 1'b0};

endpackage

/* fpp_clkdiv.sv */
// Purpose: derive the flash input clock from the system clock
// Assumes: HALF_DIV system cycles per half period
// Notes:   50 MHz cannot give 6 MHz exactly; default yields 6.25 MHz
`timescale 1ns/1ns
module fpp_clkdiv
	import fpp_pkg::*;
#(
	parameter int unsigned HALF_DIV = CLK_HALF_DIV
) (
	input  wire logic sys_clk,
	input  wire logic arst_n,
	input  wire logic clk_en,
	output logic      clk_out
);

	logic [7:0] cnt_r;

	// Toggle output every HALF_DIV cycles
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r   <= 8'h00;
			clk_out <= 1'b0;
		end else if (clk_en) begin
			if (cnt_r == 8'(HALF_DIV - 1)) begin
				cnt_r   <= 8'h00;
				clk_out <= ~clk_out;
			end else begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end

endmodule // fpp_clkdiv

/* fpp_cycle.sv */
// Purpose: one flash bus cycle, write or read, with setup, strobe and hold
// Assumes: din_sync already passed two flip-flops
// Notes:   read data are sampled in the last strobe cycle
`timescale 1ns/1ns
module fpp_cycle
	import fpp_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	input  wire logic              clk_en,
	input  wire logic              start,
	input  wire fpp_req_t          req,
	input  wire logic [DATA_W-1:0] din_sync,
	output logic                   busy,
	output logic                   done,
	output logic [DATA_W-1:0]      rdata,
	output fpp_pins_t              pins
);

	fpp_phase_t ph_r;
	logic [7:0] cnt_r;
	logic       wr_r;

	assign busy = (ph_r != PH_IDLE);

	// Phase sequencer; chip enable stays low across the whole cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ph_r  <= PH_IDLE;
			cnt_r <= 8'h00;
			wr_r  <= 1'b0;
			done  <= 1'b0;
			rdata <= 8'h00;
			pins  <= PINS_IDLE;
		end else if (clk_en) begin
			done <= 1'b0;
			case (ph_r)
				PH_IDLE: begin
					if (start) begin
						ph_r      <= PH_SETUP;
						cnt_r     <= 8'(SETUP_CYC - 1);
						wr_r      <= req.wr;
						pins.ce_n <= 1'b0;
						pins.addr <= req.addr;
						pins.dout <= req.data;
						pins.doe  <= req.wr; // Drive bus only on writes
					end
				end
				PH_SETUP: begin
					if (cnt_r == 8'h00) begin
						ph_r      <= PH_PULSE;
						cnt_r     <= 8'(PULSE_CYC - 1);
						pins.we_n <= ~wr_r; // Command write strobe
						pins.oe_n <= wr_r;  // Read strobe
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				PH_PULSE: begin
					if (cnt_r == 8'h00) begin
						// Rising write enable with chip enable still low
						ph_r      <= PH_HOLD;
						cnt_r     <= 8'(HOLD_CYC - 1);
						pins.we_n <= 1'b1;
						pins.oe_n <= 1'b1;
						if (!wr_r) begin
							rdata <= din_sync;
						end
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				PH_HOLD: begin
					if (cnt_r == 8'h00) begin
						ph_r      <= PH_IDLE;
						pins.ce_n <= 1'b1;
						pins.doe  <= 1'b0;
						done      <= 1'b1;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				default: begin
					ph_r <= PH_IDLE;
					pins <= PINS_IDLE;
				end
			endcase
		end
	end

endmodule // fpp_cycle

/* fpp_host_assertions.sv */
// Purpose: port-level checks of the flash programmer port controller
// Assumes: one clock domain, async active-low reset
// Notes:   timing figures follow the hand-over strobe walk
`timescale 1ns/1ns
module fpp_host_assertions
	import fpp_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              arst_n,
	input wire logic              mode_select_2,
	input wire logic              mode_select_1,
	input wire logic              mode_select_0,
	input wire logic              flash_write_permit,
	input wire logic              fl_ce_n,
	input wire logic              fl_oe_n,
	input wire logic              fl_we_n,
	input wire logic [ADDR_W-1:0] fl_addr,
	input wire logic [DATA_W-1:0] fl_data_o,
	input wire logic              fl_data_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Pin-level strobe rules
	AST_MODE_PINS: assert property ({mode_select_2, mode_select_1, mode_select_0} == 3'h3)
		else $error("mode pins wrong");
	AST_STROBE_EXCL: assert property (!(!fl_we_n && !fl_oe_n))
		else $error("write and output enable both low");
	AST_NO_FIGHT: assert property (!fl_oe_n |-> !fl_data_oe)
		else $error("host drives data during read");
	AST_WE_IN_CE: assert property (!fl_we_n |-> !fl_ce_n)
		else $error("write strobe outside chip enable");
	AST_WE_WIDTH: assert property ($fell(fl_we_n) |->
		(!fl_we_n)[*5] ##1 (!fl_we_n)[*5] ##1 fl_we_n)
		else $error("write strobe width wrong");
	AST_CMD_STABLE: assert property (!fl_we_n |->
		fl_data_oe && $stable(fl_data_o) && $stable(fl_addr))
		else $error("command byte moves under write strobe");
	AST_CE_WINDOW: assert property ($fell(fl_ce_n) |->
		##19 !fl_ce_n ##1 fl_ce_n ##1 fl_ce_n)
		else $error("chip enable window wrong");
	// Permit must already be up when an erase or program code is latched
	AST_PERMIT: assert property ($rose(fl_we_n) &&
		fl_data_o inside {8'h40, 8'h45, 8'h20, 8'h25} |-> flash_write_permit)
		else $error("write permit low at program or erase code");
endmodule // fpp_host_assertions

/* fpp_flash_model.sv */
// Purpose: behavioural flash in programmer mode, far side of the controller
// Assumes: commands latched on write-enable rise, busy time counted in flash clocks
// Notes:   erased bytes read FF; viol counts protocol breaches by the host
`timescale 1ns/1ns
module fpp_flash_model
	import fpp_pkg::*;
(
	input  wire logic        arst_n,
	input  wire logic        fl_clk,
	input  wire logic [2:0]  mode_sel,
	input  wire logic        flash_write_permit,
	input  wire logic        fl_ce_n,
	input  wire logic        fl_oe_n,
	input  wire logic        fl_we_n,
	input  wire logic [19:0] fl_addr,
	input  wire logic [7:0]  fl_data_o,
	input  wire logic        fail_i,
	input  wire logic [7:0]  busy_len,
	output logic             dev_oe,
	output logic [7:0]       dev_dout,
	output logic [7:0]       viol
);
	logic [7:0]  mem [logic [20:0]];
	logic [20:0] dq [$];
	logic [7:0]  pg [128];
	logic [7:0]  code, first, n;
	logic [19:0] pa;
	logic [2:0]  md;
	logic        boot, bad;
	int          tick = 0, due = 0;

	// Internal time runs on regardless of chip enable
	always @(posedge fl_clk) tick++;

	// Command decode on write-enable rise
	always @(posedge fl_we_n or negedge arst_n) begin
		if (!arst_n) begin
			md = 3'h1;
			code = 8'h00;
			viol = 8'h00;
			boot = 1'b0;
			n = 8'h00;
		end else if (!fl_ce_n) begin
			if (tick < due || mode_sel !== 3'h3) viol++;
			case (md)
				3'h2: begin
					if (n == 8'h00) pa = fl_addr;
					pg[n[6:0]] = fl_data_o;
					n++;
					if (n == 8'h80) begin
						bad = fail_i || pa[6:0] != 7'h00;
						for (int i = 0; i < 128; i++) begin
							if (mem.exists({boot, pa[19:7], i[6:0]})) bad = 1'b1;
							mem[{boot, pa[19:7], i[6:0]}] = pg[i];
						end
						code = bad ? 8'hA0 : 8'h00;
						md = 3'h5;
						due = tick + busy_len;
					end
				end
				3'h3: begin
					if (fl_data_o !== first) viol++;
					dq.delete();
					foreach (mem[key]) if (key[20] == boot) dq.push_back(key);
					foreach (dq[j]) mem.delete(dq[j]);
					code = fail_i ? 8'h90 : 8'h00;
					md = 3'h5;
					due = tick + busy_len;
				end
				3'h4: md = (fl_data_o === 8'h71) ? 3'h6 : 3'h0;
				default: begin
					first = fl_data_o;
					boot = fl_data_o[0];
					n = 8'h00;
					case (fl_data_o)
						8'h00, 8'h05: md = 3'h1;
						8'h40, 8'h45: md = 3'h2;
						8'h20, 8'h25: md = 3'h3;
						8'h71: md = 3'h4;
						default: begin
							md = 3'h0;
							code = 8'hC0;
						end
					endcase
					if (md inside {3'h2, 3'h3} && !flash_write_permit) viol++;
				end
			endcase
		end
	end

	// Read data; tick is an argument so polling re-evaluates
	function automatic logic [7:0] look(input logic [2:0] m, input logic [19:0] ad, input int t);
		logic d;
		d = t >= due;
		case (m)
			3'h1: return mem.exists({boot, ad}) ? mem[{boot, ad}] : 8'hFF;
			3'h5: return {d, d & ~code[7], 6'h00};
			3'h6: return code;
			default: return 8'h00;
		endcase
	endfunction

	assign dev_oe = !fl_ce_n && !fl_oe_n && fl_we_n;
	assign dev_dout = look(md, fl_addr, tick);
endmodule // fpp_flash_model

/* tb.sv */
// Purpose: self-checking bench of the flash programmer port controller
// Assumes: register port with read data one cycle after the strobe
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/1ns
module tb;
	import fpp_pkg::*;
	logic              sys_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic [7:0]        reg_addr = 8'h00;
	logic [31:0]       reg_wdata = 32'h0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic              clk_en = 1'b1;
	logic              pad = 1'b0;
	logic              fail_i = 1'b0;
	logic [7:0]        busy_len = 8'h02;
	logic [31:0]       reg_rdata, v, lfsr = 32'h6495D582;
	logic [7:0]        fl_data_o, fl_data_i, dev_dout, viol, last = 8'h00;
	logic [19:0]       fl_addr, a;
	logic [7:0]        pg [128];
	logic              fl_clk, ms2, ms1, ms0, fwp, ce_n, oe_n, we_n, doe, dev_oe;
	int                fails = 0;
	int                comparisons = 0;
	int                cyc = 0;

	always #10 sys_clk = ~sys_clk;

	// Wire level from both parties; undriven shows a changing pattern
	assign fl_data_i = dev_oe ? dev_dout : (doe ? fl_data_o : ~last);
	always @(posedge sys_clk) last <= fl_data_i;

	fpp_host fpp_host_inst (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .fl_clk(fl_clk), .mode_select_2(ms2), .mode_select_1(ms1),
		.mode_select_0(ms0), .flash_write_permit(fwp), .fl_ce_n(ce_n), .fl_oe_n(oe_n),
		.fl_we_n(we_n), .fl_addr(fl_addr), .fl_data_o(fl_data_o), .fl_data_oe(doe),
		.fl_data_i(fl_data_i));

	fpp_flash_model fpp_flash_model_inst (.arst_n(arst_n), .fl_clk(fl_clk),
		.mode_sel({ms2, ms1, ms0}), .flash_write_permit(fwp), .fl_ce_n(ce_n),
		.fl_oe_n(oe_n), .fl_we_n(we_n), .fl_addr(fl_addr), .fl_data_o(fl_data_o),
		.fail_i(fail_i), .busy_len(busy_len), .dev_oe(dev_oe), .dev_dout(dev_dout),
		.viol(viol));

	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic print_verdict();
		if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (e !== g) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad);
		@(posedge sys_clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// One operation, feeding program bytes on request, until done
	task automatic run(input logic [2:0] o, input logic b, input logic [19:0] ad);
		int k;
		k = 0;
		wr(REG_ADDR, {12'h000, ad});
		wr(REG_CTRL, {27'h0, b, o, 1'h1});
		for (int i = 0; i < 9000; i++) begin
			rd(REG_STAT);
			if (v[2]) break;
			if (v[1] && k < 128) begin
				wr(REG_DATA, {23'h0, pad, pg[k]});
				k++;
			end
		end
	endtask

	// Hang guard, generous against the longest expected run
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			print_verdict();
		end
	end

	initial begin
		for (int j = 0; j < 128; j++) begin
			lfsr = nx(lfsr);
			pg[j] = lfsr[7:0];
		end
		lfsr = nx(lfsr);
		a = lfsr[19:0] | 20'h00011;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		clk_en <= 1'b0;
		rd(REG_STAT);
		chk("frozen", 32'h0, v);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		rd(REG_STAT);
		chk("mread", 32'h1, {31'h0, v[6]});
		run(3'h1, 1'h0, a);
		chk("erased", 32'hFF, {24'h0, v[15:8]});
		busy_len <= 8'h28;
		run(3'h2, 1'h0, a);
		chk("prog", 32'h0C, {26'h0, v[5:0]});
		run(3'h1, 1'h0, a);
		chk("no_read", 32'h1, {31'h0, v[5]});
		run(3'h0, 1'h0, a);
		run(3'h1, 1'h0, {a[19:7], 7'h05});
		chk("byte5", {24'h0, pg[5]}, {24'h0, v[15:8]});
		run(3'h1, 1'h0, {a[19:7], 7'h7F});
		chk("byte127", {24'h0, pg[127]}, {24'h0, v[15:8]});
		run(3'h2, 1'h0, a);
		chk("reprog", 32'h1, {31'h0, v[5]});
		for (int b = 0; b < 2; b++) begin
			busy_len <= 8'h05 + 8'(b * 30);
			run(3'h3, b[0], 20'h00000);
			chk("erase", 32'h0C, {26'h0, v[5:0]});
		end
		run(3'h0, 1'h0, a);
		run(3'h1, 1'h0, a);
		chk("wiped", 32'hFF, {24'h0, v[15:8]});
		pad = 1'b1;
		fail_i <= 1'b1;
		run(3'h2, 1'h1, a);
		chk("abnormal", 32'h2, {30'h0, v[4:3]});
		fail_i <= 1'b0;
		run(3'h4, 1'h0, 20'h00000);
		chk("code", 32'hA0, {24'h0, v[23:16]});
		run(3'h4, 1'h0, 20'h00000);
		chk("code_kept", 32'hA0, {24'h0, v[23:16]});
		run(3'h0, 1'h1, a);
		run(3'h1, 1'h1, {a[19:7], 7'h00});
		chk("pad_first", {24'h0, pg[0]}, {24'h0, v[15:8]});
		run(3'h1, 1'h1, {a[19:7], 7'h01});
		chk("pad_fill", 32'hFF, {24'h0, v[15:8]});
		chk("breaches", 32'h0, {24'h0, viol});
		print_verdict();
	end
endmodule // tb

bind fpp_host fpp_host_assertions fpp_host_assertions_inst (
	.sys_clk(sys_clk), .arst_n(arst_n), .mode_select_2(mode_select_2),
	.mode_select_1(mode_select_1), .mode_select_0(mode_select_0),
	.flash_write_permit(flash_write_permit), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
	.fl_we_n(fl_we_n), .fl_addr(fl_addr), .fl_data_o(fl_data_o), .fl_data_oe(fl_data_oe)
);
